/* File: core/branch_seq_pkg.sv */
// Constants and types shared by the branch fetch sequencer
package branch_seq_pkg;
    localparam int ADDR_W = 32;
    // Instruction lengths in bytes
    localparam logic [31:0] LEN_WIDE = 32'h0000_0004;
    localparam logic [31:0] LEN_COMP = 32'h0000_0002;
    // Access size codes
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    // Link value corrections
    localparam logic [31:0] LINK_ADJ_WIDE = 32'h0000_0004;
    localparam logic [31:0] LINK_ADJ_COMP = 32'h0000_0002;
    // Reset values
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic [31:0] LINK_RESET = 32'h0000_0000;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_LONG1 = 5'h02,
        ST_CYC1 = 5'h04,
        ST_CYC2 = 5'h08,
        ST_CYC3 = 5'h10
    } seq_state_t;
endpackage

/* File: core/fetch_addr_step.sv */
// Fetch address stepper: adds a multiple of the instruction length
module fetch_addr_step
    import branch_seq_pkg::*;
(
    input wire logic [31:0] base,
    input wire logic compressed,
    input wire logic [1:0] mult,
    output logic [31:0] addr
);
    // Length times 0..3, added to the base
    always_comb
    begin
        addr = base + ((compressed ? LEN_COMP : LEN_WIDE)
            * {30'h0, mult});
    end
endmodule

/* File: core/branch_fetch_sequencer.sv */
// Bus-cycle sequencer for branch and long branch-with-link fetches
//
// Overview of operation
// - Request and burst-continue outputs announce the next cycle type.
// - Address and qualifiers are presented for the cycle they belong to.
// - Prefetch address steps by four (wide state) or two (compressed).
// - Access size is word in wide state, halfword in compressed state.
// - Branch cycle one computes target while prefetching from pc.
// - Cycle two fetches target; link branch writes return address to link.
// - Cycle three fetches target plus length; link value reduced by four.
// - Three fetches: pc+2L non-sequential, then alu and alu+L sequential.
// - Single-instruction link branch is refused in compressed state.
// - Long link first half adds pc to upper offset into link register.
// - Long link second half cycle one computes target, prefetches at pc.
// - Second half cycle two fetches target and writes return address.
// - Second half cycle three fetches target plus two, link minus two.
// - Four halfword fetches: pc+4 seq, pc+6 nonseq, alu, alu+2 seq.
module branch_fetch_sequencer
    import branch_seq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic compressed_state_flag_in,
    input wire logic start_branch,
    input wire logic link_bit,
    input wire logic start_long_link,
    input wire logic [31:0] pc,
    input wire logic [31:0] target,
    input wire logic [31:0] upper_offset,
    output logic busy,
    output logic refused,
    output logic [31:0] addr,
    output logic [1:0] access_size,
    output logic write_not_read,
    output logic instr_fetch_n,
    output logic user_privilege_n,
    output logic compressed_state_flag,
    output logic mem_request_n,
    output logic burst_continue,
    output logic [31:0] link_reg,
    output logic link_we
);

    ////////////////////////////////////////////////////////////////////////
    // State record
    typedef struct packed {
        seq_state_t st;
        logic comp;
        logic link;
        logic is_long;
        logic [31:0] pc;
        logic [31:0] alu;
        logic [31:0] addr;
        logic [1:0] size;
        logic req_n;
        logic seq;
        logic [31:0] lr;
        logic lr_we;
        logic refused;
    } state_t;

    state_t cur;
    state_t next_cur;
    logic [31:0] step_addr;
    logic [31:0] step_base;
    logic [1:0] step_mult;
    // Stepper length flag kept apart from next_cur to avoid a comb loop
    logic step_comp;

    // Access size code for a state flag
    function automatic logic [1:0] size_for(input logic comp);
        return comp ? SIZE_HALF : SIZE_WORD;
    endfunction

    fetch_addr_step u_step (
        .base(step_base),
        .compressed(step_comp),
        .mult(step_mult),
        .addr(step_addr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic; addresses are registered so they are stable a cycle
    always_comb
    begin
        next_cur = cur;
        next_cur.lr_we = 1'b0;
        next_cur.refused = 1'b0;
        // Default step of zero holds the last address while idle
        step_base = cur.addr;
        step_mult = 2'h0;
        step_comp = cur.comp;
        unique case (cur.st)
            ST_IDLE:
            begin
                next_cur.req_n = 1'b0;
                next_cur.seq = 1'b1;
                next_cur.comp = compressed_state_flag_in;
                step_comp = compressed_state_flag_in;
                if (start_long_link && compressed_state_flag_in)
                begin
                    // First half behaves as data op; prefetch pc+4, seq next
                    next_cur.st = ST_LONG1;
                    next_cur.pc = pc;
                    next_cur.is_long = 1'b1;
                    next_cur.link = 1'b1;
                    next_cur.lr = pc + upper_offset;
                    next_cur.lr_we = 1'b1;
                    step_base = pc;
                    step_mult = 2'h2;
                    next_cur.seq = 1'b1;
                end
                else if (start_branch &&
                    !(link_bit && compressed_state_flag_in))
                begin
                    next_cur.st = ST_CYC1;
                    next_cur.pc = pc;
                    next_cur.is_long = 1'b0;
                    next_cur.link = link_bit;
                    next_cur.alu = target;
                    step_base = pc;
                    step_mult = 2'h2;
                    next_cur.seq = 1'b0;
                end
                else if (start_branch)
                begin
                    next_cur.refused = 1'b1;
                end
                next_cur.addr = step_addr;
                next_cur.size = size_for(compressed_state_flag_in);
            end
            ST_LONG1:
            begin
                // Second half cycle one: target computed, prefetch pc+6
                next_cur.st = ST_CYC1;
                next_cur.alu = target;
                step_base = cur.pc;
                step_mult = 2'h3;
                next_cur.addr = step_addr;
                next_cur.seq = 1'b0;
            end
            ST_CYC1:
            begin
                next_cur.st = ST_CYC2;
                step_base = cur.alu;
                step_mult = 2'h0;
                next_cur.addr = step_addr;
                next_cur.seq = 1'b1;
                if (cur.link)
                begin
                    // Return address is the prefetch address of cycle one
                    next_cur.lr = cur.addr;
                    next_cur.lr_we = 1'b1;
                end
            end
            ST_CYC2:
            begin
                next_cur.st = ST_CYC3;
                step_base = cur.alu;
                step_mult = 2'h1;
                next_cur.addr = step_addr;
                next_cur.seq = 1'b1;
                if (cur.link)
                begin
                    next_cur.lr = cur.lr - (cur.comp ? LINK_ADJ_COMP
                        : LINK_ADJ_WIDE);
                    next_cur.lr_we = 1'b1;
                end
            end
            ST_CYC3:
            begin
                // Hand back to sequential fetch at alu+2L
                next_cur.st = ST_IDLE;
                step_base = cur.alu;
                step_mult = 2'h2;
                next_cur.addr = step_addr;
                next_cur.seq = 1'b1;
                next_cur.link = 1'b0;
                next_cur.is_long = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cur <= '{st: ST_IDLE, comp: 1'b0, link: 1'b0, is_long: 1'b0,
                pc: PC_RESET, alu: PC_RESET, addr: PC_RESET,
                size: SIZE_WORD, req_n: 1'b1, seq: 1'b0, lr: LINK_RESET,
                lr_we: 1'b0, refused: 1'b0};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; all reads with opcode fetch active
    assign busy = (cur.st != ST_IDLE);
    assign refused = cur.refused;
    assign addr = cur.addr;
    assign access_size = cur.size;
    assign write_not_read = 1'b0;
    assign instr_fetch_n = 1'b0;
    assign user_privilege_n = 1'b1;
    assign compressed_state_flag = cur.comp;
    assign mem_request_n = cur.req_n;
    assign burst_continue = cur.seq;
    assign link_reg = cur.lr;
    assign link_we = cur.lr_we;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_step_target;
        @(posedge clk_sys) disable iff (!rst_b)
        (cur.st == ST_CYC1) |=> (addr == cur.alu) && burst_continue;
    endproperty
    a_step_target: assert property (p_step_target)
        else $error("target fetch address wrong");

    property p_refill;
        @(posedge clk_sys) disable iff (!rst_b)
        (cur.st == ST_CYC2) |=> addr == cur.alu +
            (cur.comp ? LEN_COMP : LEN_WIDE);
    endproperty
    a_refill: assert property (p_refill)
        else $error("refill address wrong");

    property p_link_adj;
        @(posedge clk_sys) disable iff (!rst_b)
        (cur.st == ST_CYC2 && cur.link) |=> link_we &&
            link_reg == $past(link_reg) - (cur.comp ? LINK_ADJ_COMP
            : LINK_ADJ_WIDE);
    endproperty
    a_link_adj: assert property (p_link_adj)
        else $error("link adjustment wrong");

    property p_size;
        @(posedge clk_sys) disable iff (!rst_b)
        access_size == (compressed_state_flag ? SIZE_HALF : SIZE_WORD);
    endproperty
    a_size: assert property (p_size)
        else $error("access size does not match state");

    property p_nonseq_first;
        @(posedge clk_sys) disable iff (!rst_b)
        (cur.st == ST_IDLE && start_branch && !start_long_link &&
            !(link_bit && compressed_state_flag_in)) |=>
            !burst_continue && addr == $past(pc) +
            2 * (compressed_state_flag ? LEN_COMP : LEN_WIDE);
    endproperty
    a_nonseq_first: assert property (p_nonseq_first)
        else $error("first branch fetch wrong");

    property p_no_comp_link;
        @(posedge clk_sys) disable iff (!rst_b)
        (cur.st == ST_IDLE && start_branch && link_bit &&
            compressed_state_flag_in && !start_long_link) |=>
            refused && !busy;
    endproperty
    a_no_comp_link: assert property (p_no_comp_link)
        else $error("compressed link branch not refused");

    property p_long_seq;
        @(posedge clk_sys) disable iff (!rst_b)
        (cur.st == ST_IDLE && start_long_link && compressed_state_flag_in)
            |=> burst_continue ##1 !burst_continue ##1 burst_continue
            ##1 burst_continue;
    endproperty
    a_long_seq: assert property (p_long_seq)
        else $error("long link sequence flags wrong");

    property p_fetch_read;
        @(posedge clk_sys) disable iff (!rst_b)
        busy |-> !write_not_read && !instr_fetch_n && !mem_request_n;
    endproperty
    a_fetch_read: assert property (p_fetch_read)
        else $error("branch fetch not an opcode read");
endmodule

/* File: dv/mem_model.sv */
// Memory-side model that decodes the announced bus cycle types
module mem_model
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic write_not_read,
    input wire logic instr_fetch_n,
    input wire logic mem_request_n,
    input wire logic burst_continue,
    output logic cyc_valid,
    output logic cyc_seq,
    output logic bad_cycle
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////
    // Type shown one cycle early applies to the current cycle
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cyc_valid <= 1'b0;
            cyc_seq <= 1'b0;
        end
        else
        begin
            cyc_valid <= !mem_request_n;
            cyc_seq <= burst_continue;
        end
    end
    // Sticky: a write in a fetch cycle would corrupt code memory
    always_ff @(negedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            bad_cycle <= 1'b0;
        else if (cyc_valid && (write_not_read !== 1'b0
                 || instr_fetch_n !== 1'b0))
            bad_cycle <= 1'b1;
    end
endmodule

/* File: dv/branch_fetch_sequencer_test.sv */
// Self-checking bench for the branch fetch sequencer
module branch_fetch_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import branch_seq_pkg::*;
    typedef struct {logic [31:0] a; logic [1:0] s; logic q;} fetch_t;
    logic clk_sys = 0, rst_b = 0, comp_in = 0, start_branch = 0;
    logic link_bit = 0, start_long_link = 0;
    logic [31:0] pc = 0, target = 0, upper_offset = 0, addr, link_reg;
    logic [1:0] access_size;
    logic busy, refused, wnr, ifn, upn, csf, req_n, seq, link_we;
    logic cyc_valid, cyc_seq, bad_cycle;
    fetch_t fq[$];
    logic exp_q = 1'b1;
    logic [31:0] lq[$];
    int n_fail = 0, checks = 0, nref = 0, nref_exp = 0;
    ////////////////////////////////////////////////////////////////////
    branch_fetch_sequencer dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .compressed_state_flag_in(comp_in), .start_branch(start_branch),
        .link_bit(link_bit), .start_long_link(start_long_link), .pc(pc),
        .target(target), .upper_offset(upper_offset), .busy(busy),
        .refused(refused), .addr(addr), .access_size(access_size),
        .write_not_read(wnr), .instr_fetch_n(ifn),
        .user_privilege_n(upn), .compressed_state_flag(csf),
        .mem_request_n(req_n), .burst_continue(seq),
        .link_reg(link_reg), .link_we(link_we));
    mem_model mem (.clk_sys(clk_sys), .rst_b(rst_b), .write_not_read(wnr),
        .instr_fetch_n(ifn), .mem_request_n(req_n),
        .burst_continue(seq), .cyc_valid(cyc_valid), .cyc_seq(cyc_seq),
        .bad_cycle(bad_cycle));
    ////////////////////////////////////////////////////////////////////
    // 20 MHz system clock
    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task conclude;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // One branch; notes expectations, then starts it at a falling edge
    task automatic op(input logic lng, input logic comp, input logic lnk);
        logic [31:0] p, t, u, l;
        logic [1:0] sz;
        int n;
        p = $urandom() & 32'h00ff_fffc;
        t = $urandom() & 32'h00ff_fffc;
        u = $urandom() & 32'h000f_f000;
        l = comp ? LEN_COMP : LEN_WIDE;
        sz = comp ? SIZE_HALF : SIZE_WORD;
        if (lng)
        begin
            fq.push_back('{p + 32'h4, SIZE_HALF, 1'b1});
            fq.push_back('{p + 32'h6, SIZE_HALF, 1'b0});
            fq.push_back('{t, SIZE_HALF, 1'b1});
            fq.push_back('{t + 32'h2, SIZE_HALF, 1'b1});
            lq.push_back(p + u);
            lq.push_back(p + 32'h6);
            lq.push_back(p + 32'h4);
        end
        else if (comp && lnk)
            nref_exp++;
        else
        begin
            fq.push_back('{p + 2 * l, sz, 1'b0});
            fq.push_back('{t, sz, 1'b1});
            fq.push_back('{t + l, sz, 1'b1});
            if (lnk)
            begin
                lq.push_back(p + 32'h8);
                lq.push_back(p + 32'h4);
            end
        end
        pc = p;
        target = t;
        upper_offset = u;
        comp_in = comp;
        link_bit = lnk;
        start_long_link = lng;
        start_branch = !lng;
        @(negedge clk_sys);
        // A start while busy must be ignored
        start_long_link = 0;
        start_branch = lng;
        @(negedge clk_sys);
        start_branch = 0;
        for (n = 0; n < 10 && busy !== 1'b0; n++)
            @(negedge clk_sys);
        if (comp && lnk && !lng)
            @(negedge clk_sys);
        else
            cmp("next fetch", t + 2 * l, addr);
    endtask
    ////////////////////////////////////////////////////////////////////
    // Output watcher; takes the oldest note whenever a result shows
    always @(negedge clk_sys)
    begin
        if (busy === 1'b1)
        begin
            if (fq.size() == 0)
                fq.push_back('{32'hx, 2'hx, 1'bx});
            cmp("addr", fq[0].a, addr);
            cmp("access_size", fq[0].s, access_size);
            cmp("burst_continue", fq[0].q, seq);
            cmp("state flag", fq[0].s == SIZE_HALF, csf);
            cmp("cycle requested", 1, cyc_valid);
            cmp("cycle type", exp_q, cyc_seq);
            cmp("user_privilege_n", 1, upn);
            exp_q = fq[0].q;
            void'(fq.pop_front());
        end
        else
            exp_q = 1'b1;
        if (link_we === 1'b1)
        begin
            if (lq.size() == 0)
                lq.push_back(32'hx);
            cmp("link_reg", lq.pop_front(), link_reg);
        end
        if (refused === 1'b1)
            nref++;
    end
    // Watchdog well beyond the expected run length
    initial
    begin
        #100us;
        n_fail++;
        conclude();
    end
    initial
    begin
        void'($urandom(13));
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_b = 1;
        // One idle cycle so the first fetch has been announced
        @(negedge clk_sys);
        for (int i = 0; i < 3; i++)
        begin
            op(0, 0, 0);
            op(0, 0, 1);
            op(0, 1, 0);
            op(0, 1, 1);
            op(1, 1, 0);
            $display("test round %0d done", i);
        end
        repeat (3) @(negedge clk_sys);
        cmp("notes left", 0, fq.size() + lq.size());
        cmp("refusals", nref_exp, nref);
        cmp("bus fault", 0, bad_cycle);
        conclude();
    end
endmodule
